// ---- rtl/eirq_pkg.sv ----
// constants, field layout and types for the external interrupt block
package eirq_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;
  localparam int          VEC_W       = 16;
  // register indices; byte address is four times the index
  localparam logic [7:0]  LINE1_IDX   = 8'h0A;
  localparam logic [7:0]  LINE2_IDX   = 8'h0B;
  localparam logic [7:0]  OPTION_IDX  = 8'h1D;
  localparam logic [7:0]  CTCS_IDX    = 8'h08;
  localparam logic [7:0]  CTCNT_IDX   = 8'h09;
  // line control/status fields
  localparam int          PEND_BIT    = 5;
  localparam int          EN_BIT      = 4;
  localparam int          LV_BIT      = 3;
  localparam int          EDG_BIT     = 2;
  localparam int          CLR_BIT     = 1;
  localparam int          PIN_BIT     = 0;
  localparam int          LINE0_SEL_BIT = 1;
  // core timer control/status fields
  localparam int          CT_OVF_FLAG_BIT = 7;
  localparam int          CT_RT_FLAG_BIT  = 6;
  localparam int          CT_OVF_EN_BIT   = 5;
  localparam int          CT_RT_EN_BIT    = 4;
  localparam int          CT_OVF_CLR_BIT  = 3;
  localparam int          CT_RT_CLR_BIT   = 2;
  localparam int          CT_RATE_LSB     = 0;
  localparam int          CT_RATE_W       = 2;
  localparam int          CT_RT_BASE_BITS = 4;
  // reset values
  localparam logic        LINE_EN_RST  = 1'b0;
  localparam logic        LINE_LV_RST  = 1'b0;
  localparam logic        LINE_EDG_RST = 1'b0;
  localparam logic        LINE0_SEL_RST = 1'b0;
  localparam logic [7:0]  CTCNT_RST    = 8'h00;
  localparam logic [1:0]  CT_RATE_RST  = 2'h0;
  // vectors, most significant byte location
  localparam logic [15:0] VEC_RESET    = 16'h3FFE;
  localparam logic [15:0] VEC_TRAP     = 16'h3FFC;
  localparam logic [15:0] VEC_EXT      = 16'h3FFA;
  localparam logic [15:0] VEC_CT       = 16'h3FF8;
  localparam logic [15:0] VEC_SER      = 16'h3FF6;
  localparam logic [15:0] VEC_PT       = 16'h3FF4;
  // timing
  localparam int          CLK_NS       = 10;
  localparam int          CT_TICK_NS   = 40;
  localparam int          CT_TICK_CYC  = (CT_TICK_NS + CLK_NS - 1) / CLK_NS;
  // bus answers, then timer and serial request flag counts
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          PT_FLAGS     = 5;
  localparam int          SER_FLAGS    = 4;

  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP} eirq_pwr_e;
endpackage

// ---- rtl/eirq_line_trig.sv ----
// one external line: synchroniser, sensitivity select and pending flag
`timescale 1ns/10ps
module eirq_line_trig (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  input  wire logic level_sel,
  input  wire logic polarity_sel,
  input  wire logic clear,
  output logic      pin_level,
  output logic      pending_flag
);
  logic sync1_reg;
  logic prev_reg;
  logic rise;
  logic fall;
  logic trig;

  // two-stage synchroniser, pin_level is the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      pin_level <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin;
      pin_level <= sync1_reg;
      prev_reg  <= pin_level;
    end
  end

  assign rise = pin_level & ~prev_reg;
  assign fall = ~pin_level & prev_reg;
  // edge by polarity, plus matching level when level mode is set
  assign trig = (polarity_sel ? rise : fall) |
                (level_sel & (pin_level == polarity_sel));

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn)
      pending_flag <= 1'b0;
    else if (trig)
      pending_flag <= 1'b1;
    else if (clear)
      pending_flag <= 1'b0;
  end
endmodule

// ---- rtl/eirq_ctrl.sv ----
// external interrupt lines, timer request summaries, vectoring and power
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module eirq_ctrl
  import eirq_pkg::*;
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [eirq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [eirq_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [eirq_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [eirq_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       ext_req_line_0_n,
  input  wire logic                       ext_req_line_1,
  input  wire logic                       ext_req_line_2,
  input  wire logic [eirq_pkg::PT_FLAGS-1:0]  prog_timer_status,
  input  wire logic [eirq_pkg::PT_FLAGS-1:0]  prog_timer_ctrl,
  input  wire logic [eirq_pkg::SER_FLAGS-1:0] serial_flags,
  input  wire logic [eirq_pkg::SER_FLAGS-1:0] serial_enables,
  input  wire logic                       instr_done,
  input  wire logic                       soft_trap,
  input  wire logic                       mask_set,
  input  wire logic                       mask_clear,
  input  wire logic                       stop_req,
  input  wire logic                       wait_req,
  output logic                            svc_valid,
  output logic [eirq_pkg::VEC_W-1:0]      svc_vector,
  output logic                            cond_code_mask,
  output logic                            ext_vec_req,
  output logic                            osc_enable,
  output logic                            cpu_clk_run,
  output logic                            prog_timer_run
);
  import eirq_pkg::*;

  localparam logic [ADDR_W-1:0] LINE1_ADDR  = ADDR_W'({LINE1_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] LINE2_ADDR  = ADDR_W'({LINE2_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] OPTION_ADDR = ADDR_W'({OPTION_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] CTCS_ADDR   = ADDR_W'({CTCS_IDX, 2'b00});
  localparam logic [ADDR_W-1:0] CTCNT_ADDR  = ADDR_W'({CTCNT_IDX, 2'b00});

  // bus state
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [REG_W-1:0]  w_data_reg;
  logic              w_lane_reg;
  logic              wr_fire;
  logic              wr_hit;
  logic              rd_hit;
  logic [REG_W-1:0]  rd_byte;

  // line control fields
  logic [2:1] line_en_reg;
  logic [2:1] line_lv_reg;
  logic [2:1] line_edg_reg;
  logic [2:1] line_clr;
  logic [2:1] line_pin;
  logic [2:1] line_pend;
  logic [2:1] line_pin_in;
  logic       line0_edge_only_sel;
  logic       line0_sel_locked_reg;

  // line 0 capture path
  logic line0_prev_reg;
  logic line0_latch_reg;
  logic line0_sync1_reg;
  logic line0_sync2_reg;
  logic line0_lvl1_reg;
  logic line0_lvl2_reg;
  logic line0_req;

  // core timer
  logic [7:0]             core_tick_counter;
  logic [$clog2(CT_TICK_CYC+1)-1:0] ct_pre_reg;
  logic                   ct_tick;
  logic                   core_ctr_overflow_flag;
  logic                   realtime_tick_flag;
  logic                   core_ctr_overflow_enable;
  logic                   realtime_tick_enable;
  logic [CT_RATE_W-1:0]   ct_rate_reg;
  logic                   rt_due;
  logic                   ct_req;
  logic [REG_W-1:0]       ctcs_rd;

  logic pt_req;
  logic ser_req;
  logic ext_req;
  logic any_req;
  logic reset_fetch_reg;
  eirq_pwr_e pwr_reg;

  // ---- bus write channel ----
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_hit  = (aw_addr_reg == LINE1_ADDR) | (aw_addr_reg == LINE2_ADDR) |
                   (aw_addr_reg == OPTION_ADDR) | (aw_addr_reg == CTCS_ADDR) |
                   (aw_addr_reg == CTCNT_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_lane_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[REG_W-1:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---- line 1/2 control fields ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_en_reg  <= {2{LINE_EN_RST}};
      line_lv_reg  <= {2{LINE_LV_RST}};
      line_edg_reg <= {2{LINE_EDG_RST}};
    end else if (wr_fire & w_lane_reg) begin
      if (aw_addr_reg == LINE1_ADDR) begin
        line_en_reg[1]  <= w_data_reg[EN_BIT];
        line_lv_reg[1]  <= w_data_reg[LV_BIT];
        line_edg_reg[1] <= w_data_reg[EDG_BIT];
      end
      if (aw_addr_reg == LINE2_ADDR) begin
        line_en_reg[2]  <= w_data_reg[EN_BIT];
        line_lv_reg[2]  <= w_data_reg[LV_BIT];
        line_edg_reg[2] <= w_data_reg[EDG_BIT];
      end
    end
  end

  assign line_clr[1] = wr_fire & w_lane_reg & (aw_addr_reg == LINE1_ADDR) &
                       w_data_reg[CLR_BIT];
  assign line_clr[2] = wr_fire & w_lane_reg & (aw_addr_reg == LINE2_ADDR) &
                       w_data_reg[CLR_BIT];
  assign line_pin_in = {ext_req_line_2, ext_req_line_1};

  genvar gi;
  generate
    for (gi = 1; gi <= 2; gi++) begin : g_line
      eirq_line_trig u_trig (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .pin          (line_pin_in[gi]),
        .level_sel    (line_lv_reg[gi]),
        .polarity_sel (line_edg_reg[gi]),
        .clear        (line_clr[gi]),
        .pin_level    (line_pin[gi]),
        .pending_flag (line_pend[gi])
      );
    end
  endgenerate

  // ---- line 0 trigger select, accepted once after reset ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line0_edge_only_sel  <= LINE0_SEL_RST;
      line0_sel_locked_reg <= 1'b0;
    end else if (wr_fire & w_lane_reg & (aw_addr_reg == OPTION_ADDR) &
                 ~line0_sel_locked_reg) begin
      line0_edge_only_sel  <= w_data_reg[LINE0_SEL_BIT];
      line0_sel_locked_reg <= 1'b1;
    end
  end

  // ---- line 0: falling edge latched, then synchronised ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line0_prev_reg  <= 1'b1;
      line0_latch_reg <= 1'b0;
    end else begin
      line0_prev_reg <= ext_req_line_0_n;
      if (line0_prev_reg & ~ext_req_line_0_n)
        line0_latch_reg <= 1'b1;
      else if (svc_valid & (svc_vector == VEC_EXT))
        line0_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line0_sync1_reg <= 1'b0;
      line0_sync2_reg <= 1'b0;
      line0_lvl1_reg  <= 1'b0;
      line0_lvl2_reg  <= 1'b0;
    end else begin
      // an issued external vector also empties the capture chain
      if (svc_valid & (svc_vector == VEC_EXT)) begin
        line0_sync1_reg <= 1'b0;
        line0_sync2_reg <= 1'b0;
      end else begin
        line0_sync1_reg <= line0_latch_reg;
        line0_sync2_reg <= line0_sync1_reg;
      end
      line0_lvl1_reg  <= ~ext_req_line_0_n;
      line0_lvl2_reg  <= line0_lvl1_reg;
    end
  end

  assign line0_req = line0_sync2_reg |
                     (~line0_edge_only_sel & line0_lvl2_reg);
  assign ext_req = line0_req | (line_en_reg[1] & line_pend[1]) |
                   (line_en_reg[2] & line_pend[2]);

  // ---- core timer: prescaled 8-bit counter, runs unless stopped ----
  assign ct_tick = (ct_pre_reg == '0) & (pwr_reg != PWR_STOP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ct_pre_reg        <= '0;
      core_tick_counter <= CTCNT_RST;
    end else if (pwr_reg != PWR_STOP) begin
      if (ct_pre_reg == '0)
        ct_pre_reg <= ($bits(ct_pre_reg))'(CT_TICK_CYC - 1);
      else
        ct_pre_reg <= ct_pre_reg - 1'b1;
      if (ct_tick)
        core_tick_counter <= core_tick_counter + 8'h01;
    end
  end

  assign rt_due = ct_tick &
    ((core_tick_counter &
      8'((9'h001 << (CT_RT_BASE_BITS + int'(ct_rate_reg))) - 9'h001)) ==
     8'((9'h001 << (CT_RT_BASE_BITS + int'(ct_rate_reg))) - 9'h001));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ctr_overflow_enable <= 1'b0;
      realtime_tick_enable     <= 1'b0;
      ct_rate_reg              <= CT_RATE_RST;
    end else if (wr_fire & w_lane_reg & (aw_addr_reg == CTCS_ADDR)) begin
      core_ctr_overflow_enable <= w_data_reg[CT_OVF_EN_BIT];
      realtime_tick_enable     <= w_data_reg[CT_RT_EN_BIT];
      ct_rate_reg <= w_data_reg[CT_RATE_LSB +: CT_RATE_W];
    end
  end

  // flags: a set in the same cycle as a write-one clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_ctr_overflow_flag <= 1'b0;
      realtime_tick_flag     <= 1'b0;
    end else begin
      if (core_ctr_overflow_enable & ct_tick & (core_tick_counter == 8'hFF))
        core_ctr_overflow_flag <= 1'b1;
      else if (wr_fire & w_lane_reg & (aw_addr_reg == CTCS_ADDR) &
               w_data_reg[CT_OVF_CLR_BIT])
        core_ctr_overflow_flag <= 1'b0;
      if (realtime_tick_enable & rt_due)
        realtime_tick_flag <= 1'b1;
      else if (wr_fire & w_lane_reg & (aw_addr_reg == CTCS_ADDR) &
               w_data_reg[CT_RT_CLR_BIT])
        realtime_tick_flag <= 1'b0;
    end
  end

  assign ct_req  = (core_ctr_overflow_flag & core_ctr_overflow_enable) |
                   (realtime_tick_flag & realtime_tick_enable);
  assign pt_req  = |(prog_timer_status & prog_timer_ctrl);
  assign ser_req = |(serial_flags & serial_enables);
  assign any_req = ext_req | ct_req | ser_req | pt_req;

  // ---- bus read channel ----
  assign ctcs_rd = {core_ctr_overflow_flag, realtime_tick_flag,
                    core_ctr_overflow_enable, realtime_tick_enable,
                    2'b00, ct_rate_reg};

  always_comb begin
    rd_byte = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      LINE1_ADDR:  rd_byte = {2'b00, line_pend[1], line_en_reg[1],
                              line_lv_reg[1], line_edg_reg[1], 1'b0,
                              line_pin[1]};
      LINE2_ADDR:  rd_byte = {2'b00, line_pend[2], line_en_reg[2],
                              line_lv_reg[2], line_edg_reg[2], 1'b0,
                              line_pin[2]};
      OPTION_ADDR: rd_byte = REG_W'({line0_edge_only_sel, 1'b0});
      CTCS_ADDR:   rd_byte = ctcs_rd;
      CTCNT_ADDR:  rd_byte = core_tick_counter;
      default:     rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= DATA_W'(rd_byte);
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---- mask bit and vectoring at instruction boundaries ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_code_mask  <= 1'b1;
      reset_fetch_reg <= 1'b1;
      svc_valid       <= 1'b0;
      svc_vector      <= VEC_RESET;
    end else begin
      svc_valid <= 1'b0;
      if (mask_clear)
        cond_code_mask <= 1'b0;
      if (mask_set)
        cond_code_mask <= 1'b1;
      if (instr_done & (pwr_reg == PWR_RUN)) begin
        if (reset_fetch_reg) begin
          svc_valid       <= 1'b1;
          svc_vector      <= VEC_RESET;
          reset_fetch_reg <= 1'b0;
        end else if (soft_trap) begin
          svc_valid      <= 1'b1;
          svc_vector     <= VEC_TRAP;
          cond_code_mask <= 1'b1;
        end else if (~cond_code_mask & any_req) begin
          svc_valid      <= 1'b1;
          cond_code_mask <= 1'b1;
          if (ext_req)
            svc_vector <= VEC_EXT;
          else if (ct_req)
            svc_vector <= VEC_CT;
          else if (ser_req)
            svc_vector <= VEC_SER;
          else
            svc_vector <= VEC_PT;
        end
      end
    end
  end

  // ---- low-power states ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg <= PWR_RUN;
    end else begin
      unique case (pwr_reg)
        PWR_RUN: begin
          if (stop_req)
            pwr_reg <= PWR_STOP;
          else if (wait_req)
            pwr_reg <= PWR_WAIT;
        end
        PWR_WAIT: begin
          if (ext_req | ct_req | pt_req)
            pwr_reg <= PWR_RUN;
        end
        PWR_STOP: begin
          if (ext_req)
            pwr_reg <= PWR_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_enable     <= 1'b1;
      cpu_clk_run    <= 1'b1;
      prog_timer_run <= 1'b1;
      ext_vec_req    <= 1'b0;
    end else begin
      osc_enable     <= (pwr_reg != PWR_STOP);
      cpu_clk_run    <= (pwr_reg == PWR_RUN);
      prog_timer_run <= (pwr_reg != PWR_STOP);
      ext_vec_req    <= ext_req;
    end
  end
endmodule

// ---- test/eirq_cpu_model.sv ----
// cpu core stand-in: instruction boundary pulses while the core clock runs
`timescale 1ns/10ps
module eirq_cpu_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic cpu_clk_run,
  output logic      instr_done
);
  logic [1:0] phase_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // one instruction ends every fourth cycle, none while halted
  assign instr_done = aresetn && cpu_clk_run && (phase_reg == 2'h3);
endmodule

// ---- test/eirq_ctrl_monitor.sv ----
// port-level assertions for the external interrupt block
`timescale 1ns/10ps
module eirq_ctrl_monitor (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      ext_req_line_0_n,
  input  wire logic                      mask_clear,
  input  wire logic                      stop_req,
  input  wire logic                      wait_req,
  input  wire logic                      svc_valid,
  input  wire logic [eirq_pkg::VEC_W-1:0] svc_vector,
  input  wire logic                      cond_code_mask,
  input  wire logic                      ext_vec_req,
  input  wire logic                      osc_enable,
  input  wire logic                      cpu_clk_run,
  input  wire logic                      prog_timer_run
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  svc_one_pulse_a:
    assert property (svc_valid |=> !svc_valid)
    else $error("service pulse too long");
  svc_sets_mask_a:
    assert property (svc_valid |-> cond_code_mask)
    else $error("service left mask clear");
  vector_legal_a:
    assert property (svc_valid |-> svc_vector inside {16'h3FFE,
      16'h3FFC, 16'h3FFA, 16'h3FF8, 16'h3FF6, 16'h3FF4})
    else $error("unknown vector");
  masked_hold_a:
    assert property (svc_valid && svc_vector inside {16'h3FFA, 16'h3FF8,
      16'h3FF6, 16'h3FF4} |-> !$past(cond_code_mask) || $past(mask_clear))
    else $error("maskable service while masked");
  line0_capture_a:
    assert property ($fell(ext_req_line_0_n) |-> ##[1:4] ext_vec_req)
    else $error("line 0 edge not captured");
  stop_osc_off_a:
    assert property (stop_req && cpu_clk_run && !ext_vec_req
      |-> ##2 !osc_enable)
    else $error("oscillator still on in stop");
  stop_all_halt_a:
    assert property (!osc_enable |-> !cpu_clk_run && !prog_timer_run)
    else $error("clocks running in stop");
  wait_timer_run_a:
    assert property (wait_req && !stop_req && cpu_clk_run && !ext_vec_req
      |-> ##2 (!cpu_clk_run && osc_enable && prog_timer_run))
    else $error("wait state clocks wrong");
endmodule

bind eirq_ctrl eirq_ctrl_monitor i_eirq_ctrl_monitor (.aclk, .aresetn,
  .ext_req_line_0_n, .mask_clear, .stop_req, .wait_req, .svc_valid,
  .svc_vector, .cond_code_mask, .ext_vec_req, .osc_enable, .cpu_clk_run,
  .prog_timer_run);

// ---- test/eirq_ctrl_tb.sv ----
// self-checking bench for the external interrupt block
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  mismatches++; $display("BAD %0t %h %h", $time, a, e); end end
module eirq_ctrl_tb;
  import eirq_pkg::*;
  logic                 aclk, aresetn, s_axi_awvalid, s_axi_awready;
  logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                 s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                 s_axi_rvalid, s_axi_rready, ext_req_line_0_n;
  logic                 ext_req_line_1, ext_req_line_2, instr_done;
  logic                 soft_trap, mask_set, mask_clear, stop_req;
  logic                 wait_req, svc_valid, cond_code_mask, ext_vec_req;
  logic                 osc_enable, cpu_clk_run, prog_timer_run;
  logic [PT_FLAGS-1:0]  prog_timer_status, prog_timer_ctrl;
  logic [SER_FLAGS-1:0] serial_flags, serial_enables;
  logic [VEC_W-1:0]     svc_vector;
  int                   mismatches, samples_checked, cyc;

  eirq_ctrl i_eirq_ctrl (.*);
  eirq_cpu_model i_eirq_cpu_model (.aclk, .aresetn, .cpu_clk_run,
    .instr_done);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, er)
  endtask

  // optionally unmask, then wait for the next vector taken
  task automatic svc(input logic [15:0] v, input logic clr);
    int n;
    n = 0;
    mask_clear <= clr;
    @(posedge aclk);
    mask_clear <= 1'b0;
    while (svc_valid !== 1'b1 && n < 1500) begin
      @(posedge aclk);
      n++;
    end
    `CHK(svc_valid, 1'b1)
    `CHK(svc_vector, v)
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid,
     ext_req_line_1, ext_req_line_2, soft_trap, mask_set,
     mask_clear, stop_req, wait_req} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, prog_timer_status,
     prog_timer_ctrl, serial_flags, serial_enables} = '0;
    ext_req_line_0_n = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    svc(16'h3FFE, 1'b0);
    `CHK(cond_code_mask, 1'b1)
    soft_trap <= 1'b1;
    svc(16'h3FFC, 1'b0);
    soft_trap <= 1'b0;
    rd(8'h28, 32'h0, RESP_OKAY);
    $display("test reset_trap done");
    for (int i = 0; i < 4; i++) begin
      ext_req_line_1 <= ~i[0];
      repeat (5) @(posedge aclk);
      wr(8'h28, i * 4, RESP_OKAY);
      wr(8'h28, i * 4 + 2, RESP_OKAY);
      rd(8'h28, i * 4 + 1 - i % 2, RESP_OKAY);
      ext_req_line_1 <= i[0];
      repeat (5) @(posedge aclk);
      rd(8'h28, 32 + i * 4 + i % 2, RESP_OKAY);
      wr(8'h28, i * 4 + 2, RESP_OKAY);
      rd(8'h28, (i / 2) * 32 + i * 4 + i % 2, RESP_OKAY);
    end
    ext_req_line_1 <= 1'b0;
    repeat (5) @(posedge aclk);
    wr(8'h28, 32'h12, RESP_OKAY);
    ext_req_line_1 <= 1'b1;
    repeat (5) @(posedge aclk);
    ext_req_line_1 <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK(ext_vec_req, 1'b1)
    rd(8'h28, 32'h30, RESP_OKAY);
    svc(16'h3FFA, 1'b1);
    wr(8'h28, 32'h02, RESP_OKAY);
    wr(8'h2C, 32'h04, RESP_OKAY);
    ext_req_line_2 <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(8'h2C, 32'h25, RESP_OKAY);
    `CHK(ext_vec_req, 1'b0)
    wr(8'h2C, 32'h14, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK(ext_vec_req, 1'b1)
    svc(16'h3FFA, 1'b1);
    wr(8'h2C, 32'h06, RESP_OKAY);
    rd(8'h2C, 32'h05, RESP_OKAY);
    $display("test lines done");
    rd(8'h74, 32'h0, RESP_OKAY);
    wr(8'h74, 32'h2, RESP_OKAY);
    wr(8'h74, 32'h0, RESP_OKAY);
    rd(8'h74, 32'h2, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    stop_req <= 1'b1;
    @(posedge aclk);
    stop_req <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(osc_enable, 1'b0)
    ext_req_line_0_n <= 1'b0;
    repeat (3) @(posedge aclk);
    ext_req_line_0_n <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(osc_enable, 1'b1)
    svc(16'h3FFA, 1'b1);
    $display("test line0_stop done");
    repeat (2) @(posedge aclk);
    wait_req <= 1'b1;
    @(posedge aclk);
    wait_req <= 1'b0;
    repeat (3) @(posedge aclk);
    `CHK(cpu_clk_run, 1'b0)
    `CHK(prog_timer_run, 1'b1)
    prog_timer_ctrl <= 5'h10;
    prog_timer_status <= 5'h10;
    repeat (4) @(posedge aclk);
    `CHK(cpu_clk_run, 1'b1)
    serial_flags <= 4'h8;
    serial_enables <= 4'h8;
    svc(16'h3FF6, 1'b1);
    serial_flags <= 4'h0;
    svc(16'h3FF4, 1'b1);
    prog_timer_status <= 5'h00;
    wr(8'h20, 32'h20, RESP_OKAY);
    svc(16'h3FF8, 1'b1);
    rd(8'h20, 32'hA0, RESP_OKAY);
    wr(8'h20, 32'h08, RESP_OKAY);
    wr(8'h20, 32'h11, RESP_OKAY);
    svc(16'h3FF8, 1'b1);
    rd(8'h20, 32'h51, RESP_OKAY);
    wr(8'h20, 32'h04, RESP_OKAY);
    rd(8'h20, 32'h00, RESP_OKAY);
    mask_clear <= 1'b1;
    @(posedge aclk);
    mask_clear <= 1'b0;
    mask_set <= 1'b1;
    @(posedge aclk);
    mask_set <= 1'b0;
    `CHK(cond_code_mask, 1'b0)
    @(posedge aclk);
    `CHK(cond_code_mask, 1'b1)
    $display("test wait_timers done");
    test_done();
  end
endmodule
